/* shared/far_pkg.sv */
// Shared constants and types for the fault auto-restart controller.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
package far_pkg;

  // ************************************************************
  // Clock and timing.
  // ************************************************************
  localparam longint unsigned CLK_FREQ_HZ    = 64'd200_000_000;
  localparam longint unsigned POLL_PERIOD_MS = 64'd5;
  localparam longint unsigned CLEAN_RUN_MIN  = 64'd10;
  localparam longint unsigned POLL_CYCLES_L  =
    POLL_PERIOD_MS * CLK_FREQ_HZ / 64'd1000;
  localparam longint unsigned CLEAN_CYCLES_L =
    CLEAN_RUN_MIN * 64'd60 * CLK_FREQ_HZ;
  localparam int POLL_W  = 20;
  localparam int CLEAN_W = 37;

  // ************************************************************
  // Register map and field layout.
  // ************************************************************
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] OUTSEL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS    = 8'h0C;
  localparam int CFG_LIMIT_LSB   = 0;
  localparam int CFG_CONTACT_BIT = 4;
  localparam int CFG_RESPROT_BIT = 5;
  localparam int CFG_RIDE_LSB    = 6;
  localparam int CMD_RESET_BIT   = 0;
  localparam int STAT_STATE_LSB  = 4;
  localparam int STAT_FAULT_LSB  = 8;
  localparam int OUT_N       = 5;
  localparam int OUT_SEL_W   = 6;
  localparam logic [3:0] LIMIT_MAX     = 4'hA;
  localparam logic [3:0] LIMIT_RST     = 4'h0;
  localparam logic [1:0] RIDE_RST      = 2'h0;
  localparam logic [5:0] FUNC_RESTART  = 6'h1E;
  localparam logic [5:0] FUNC_BRAKE    = 6'h0D;
  localparam logic [1:0] RIDE_CONT_A   = 2'h1;
  localparam logic [1:0] RIDE_CONT_B   = 2'h2;

  // ************************************************************
  // Types.
  // ************************************************************
  typedef struct packed {
    logic motor_too_hot;
    logic torque_detect_b;
    logic torque_detect_a;
    logic drive_overload;
    logic motor_overload;
    logic brake_switch_fault;
    logic resistor_too_hot;
    logic output_phase_loss;
    logic supply_phase_fault;
    logic low_bus_voltage_fault;
    logic high_bus_voltage_fault;
    logic fuse_blown_fault;
    logic ground_fault;
    logic overcurrent_fault;
  } far_fault_t;

  localparam int FAULT_W = $bits(far_fault_t);

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_POLL    = 4'b0010,
    ST_RESTART = 4'b0100,
    ST_TRIP    = 4'b1000
  } far_state_t;

endpackage

/* design/far_ctrl.sv */
// Fault auto-restart controller with braking resistor overheat protection.
// Fault detector levels arrive asynchronously; the register port and the
// run status come from logic on core_clk.
`timescale 1ns/1ps

// Contract
// - Restart only after diagnosis finds fault cleared.
// - Attempt limit setting, range 0..10, default 0.
// - OC, GF, fuse, OV, UV, PF, LF eligible.
// - Resistor, brake switch, overloads, torques also eligible.
// - Other faults trip to protective stop.
// - Undervoltage eligible only with ride-through 1 or 2.
// - Check for cleared fault every 5 ms.
// - Start restart once check finds no fault.
// - Count a fault following a restart attempt.
// - Ten minutes clean running resets the count.
// - Fault reset after trip clears the count.
// - Power cycle clears the count.
// - Contact select 0 keeps contact off during restart.
// - Contact select 1 drives contact during restart.
// - Output code 1E shows restart in progress.
// - Resistor protection only when its select is 1.
// - Resistor overheat raises alarm and coasts motor.
// - Output code D shows resistor or brake fault.
module far_ctrl
  import far_pkg::*;
#(
  parameter logic [POLL_W-1:0]  POLL_CYCLES  = POLL_W'(POLL_CYCLES_L),
  parameter logic [CLEAN_W-1:0] CLEAN_CYCLES = CLEAN_W'(CLEAN_CYCLES_L)
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire far_fault_t           fault_in,
  input  wire logic                 drive_running,
  output logic                      restart_cmd,
  output logic                      protect_stop,
  output logic                      coast_stop,
  output logic                      resistor_alarm,
  output logic                      fault_contact,
  output logic      [OUT_N-1:0]     mf_out
);

  // ************************************************************
  // Fault input synchronisers.
  // ************************************************************
  far_fault_t sync1_q;
  far_fault_t sync2_q;
  far_fault_t sync3_q;
  far_fault_t fault_q;

  // A level is accepted only once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < FAULT_W; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          fault_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= fault_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            fault_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  logic [3:0]                   limit_q;
  logic                         contact_sel_q;
  logic                         resprot_sel_q;
  logic [1:0]                   ride_sel_q;
  logic [OUT_N*OUT_SEL_W-1:0]   outsel_q;
  logic                         fault_reset_req;
  logic [3:0]                   limit_wr;

  // Values above ten would exceed the allowed range, so they clamp.
  assign limit_wr = (reg_wdata[CFG_LIMIT_LSB +: 4] > LIMIT_MAX) ?
                    LIMIT_MAX : reg_wdata[CFG_LIMIT_LSB +: 4];
  assign fault_reset_req = reg_wr && (reg_addr == CMD_OFS) &&
                           reg_wdata[CMD_RESET_BIT];

  // Software-written settings; each steers the controller below.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      limit_q       <= LIMIT_RST;
      contact_sel_q <= 1'b0;
      resprot_sel_q <= 1'b0;
      ride_sel_q    <= RIDE_RST;
      outsel_q      <= '0;
    end else if (reg_wr) begin
      if (reg_addr == CFG_OFS) begin
        limit_q       <= limit_wr;
        contact_sel_q <= reg_wdata[CFG_CONTACT_BIT];
        resprot_sel_q <= reg_wdata[CFG_RESPROT_BIT];
        ride_sel_q    <= reg_wdata[CFG_RIDE_LSB +: 2];
      end else if (reg_addr == OUTSEL_OFS) begin
        outsel_q <= reg_wdata[OUT_N*OUT_SEL_W-1:0];
      end
    end
  end

  // ************************************************************
  // Fault classification.
  // ************************************************************

  // Resistor overheat only counts when the protection is fitted.
  function automatic far_fault_t eff_faults(far_fault_t f, logic rp);
    far_fault_t e;
    e = f;
    e.resistor_too_hot = f.resistor_too_hot & rp;
    return e;
  endfunction

  // True when every present fault belongs to the restartable set.
  function automatic logic all_eligible(far_fault_t f, logic [1:0] rt);
    logic uv_ok;
    uv_ok = (rt == RIDE_CONT_A) || (rt == RIDE_CONT_B);
    return !f.motor_too_hot &&
           !(f.low_bus_voltage_fault && !uv_ok);
  endfunction

  far_fault_t eff_q;
  logic       any_fault;
  logic       eligible;

  assign eff_q     = eff_faults(fault_q, resprot_sel_q);
  assign any_fault = |eff_q;
  assign eligible  = all_eligible(eff_q, ride_sel_q);

  // ************************************************************
  // Poll timer and clean-running timer.
  // ************************************************************
  far_state_t         state_q;
  logic [POLL_W-1:0]  poll_cnt_q;
  logic               poll_tick;
  logic [CLEAN_W-1:0] clean_cnt_q;
  logic               clean_done;

  assign poll_tick  = (poll_cnt_q == POLL_CYCLES - POLL_W'(1));
  assign clean_done = (clean_cnt_q == CLEAN_CYCLES - CLEAN_W'(1));

  // The poll timer runs only while waiting, so the first check lands
  // one full period after the fault.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      poll_cnt_q <= '0;
    end else if (state_q != ST_POLL || poll_tick) begin
      poll_cnt_q <= '0;
    end else begin
      poll_cnt_q <= poll_cnt_q + POLL_W'(1);
    end
  end

  // Counts fault-free running; any fault or a stopped drive restarts it.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clean_cnt_q <= '0;
    end else if (any_fault || !drive_running || state_q != ST_RUN ||
                 clean_done) begin
      clean_cnt_q <= '0;
    end else begin
      clean_cnt_q <= clean_cnt_q + CLEAN_W'(1);
    end
  end

  // ************************************************************
  // Restart sequencer.
  // ************************************************************
  logic [3:0] count_q;
  logic       attempted_q;
  logic       can_retry;

  assign can_retry = eligible && (count_q < limit_q);

  // Main state machine.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (any_fault) begin
            if (can_retry && !(attempted_q && count_q + 4'h1 >= limit_q))
            begin
              state_q <= ST_POLL;
            end else begin
              state_q <= ST_TRIP;
            end
          end
        end
        ST_POLL: begin
          if (poll_tick && !any_fault) begin
            state_q <= ST_RESTART;
          end else if (!eligible) begin
            state_q <= ST_TRIP;
          end
        end
        ST_RESTART: begin
          state_q <= ST_RUN;
        end
        ST_TRIP: begin
          if (fault_reset_req && !any_fault) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_TRIP;
        end
      endcase
    end
  end

  // Attempt counter: a fault after an attempt uses one up.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_q     <= 4'h0;
      attempted_q <= 1'b0;
    end else if (state_q == ST_TRIP && fault_reset_req && !any_fault) begin
      count_q     <= 4'h0;
      attempted_q <= 1'b0;
    end else if (state_q == ST_RUN && any_fault && attempted_q) begin
      count_q     <= count_q + 4'h1;
      attempted_q <= 1'b0;
    end else if (state_q == ST_RESTART) begin
      attempted_q <= 1'b1;
    end else if (clean_done) begin
      count_q     <= 4'h0;
      attempted_q <= 1'b0;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  logic restart_busy;
  logic brake_fault;

  assign restart_busy = (state_q == ST_POLL) || (state_q == ST_RESTART);
  assign brake_fault  = eff_q.resistor_too_hot || fault_q.brake_switch_fault;

  // All outputs are registered to keep relay drivers glitch free.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      restart_cmd    <= 1'b0;
      protect_stop   <= 1'b0;
      coast_stop     <= 1'b0;
      resistor_alarm <= 1'b0;
      fault_contact  <= 1'b0;
    end else begin
      restart_cmd    <= (state_q == ST_POLL) && poll_tick && !any_fault;
      protect_stop   <= (state_q == ST_TRIP);
      coast_stop     <= eff_q.resistor_too_hot;
      resistor_alarm <= eff_q.resistor_too_hot;
      fault_contact  <= (state_q == ST_TRIP) ||
                        (restart_busy && contact_sel_q);
    end
  end

  // Multi-function outputs follow their function codes.
  generate
    for (gi = 0; gi < OUT_N; gi++) begin : g_mf
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          mf_out[gi] <= 1'b0;
        end else begin
          mf_out[gi] <=
            (outsel_q[gi*OUT_SEL_W +: OUT_SEL_W] == FUNC_RESTART &&
             restart_busy) ||
            (outsel_q[gi*OUT_SEL_W +: OUT_SEL_W] == FUNC_BRAKE &&
             brake_fault);
        end
      end
    end
  endgenerate

  // ************************************************************
  // Register read path.
  // ************************************************************
  logic [31:0] rd_d;

  // Unmapped addresses and the write-only command word read as zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    if (reg_addr == CFG_OFS) begin
      rd_d[CFG_LIMIT_LSB +: 4] = limit_q;
      rd_d[CFG_CONTACT_BIT]    = contact_sel_q;
      rd_d[CFG_RESPROT_BIT]    = resprot_sel_q;
      rd_d[CFG_RIDE_LSB +: 2]  = ride_sel_q;
    end else if (reg_addr == OUTSEL_OFS) begin
      rd_d[OUT_N*OUT_SEL_W-1:0] = outsel_q;
    end else if (reg_addr == STATUS_OFS) begin
      rd_d[3:0]                           = count_q;
      rd_d[STAT_STATE_LSB +: 4]           = state_q;
      rd_d[STAT_FAULT_LSB +: FAULT_W]     = fault_q;
    end
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_poll_clear;
    (state_q == ST_POLL) && poll_tick && !any_fault;
  endsequence

  sequence s_attempt;
    (state_q == ST_RESTART) ##1 (state_q == ST_RUN);
  endsequence

  restart_after_check_a: assert property (
    s_poll_clear |=> s_attempt)
    else $error("Restart did not follow a clean check.");

  restart_pulse_a: assert property (
    restart_cmd |-> $past(state_q) == ST_POLL && state_q == ST_RESTART)
    else $error("Restart pulse without a passed check.");

  poll_period_a: assert property (
    (poll_cnt_q != POLL_CYCLES - POLL_W'(1)) |=> state_q != ST_RESTART)
    else $error("Restart came before the poll period ended.");

  limit_block_a: assert property (
    (state_q == ST_RUN && any_fault && count_q >= limit_q) |=>
      state_q == ST_TRIP)
    else $error("Restart allowed at the limit.");

  ineligible_trip_a: assert property (
    (state_q == ST_RUN && any_fault && !eligible) |=> state_q == ST_TRIP)
    else $error("Ineligible fault did not trip.");

  contact_off_a: assert property (
    (restart_busy && !contact_sel_q) |=> !fault_contact)
    else $error("Fault contact active during restart.");

  contact_on_a: assert property (
    (restart_busy && contact_sel_q) |=> fault_contact)
    else $error("Fault contact idle during restart.");

  coast_stop_a: assert property (
    (fault_q.resistor_too_hot && resprot_sel_q) |=>
      coast_stop && resistor_alarm)
    else $error("Resistor overheat did not coast the motor.");

  resprot_off_a: assert property (
    !resprot_sel_q |=> !coast_stop)
    else $error("Resistor protection acted while disabled.");

  fault_reset_a: assert property (
    (state_q == ST_TRIP && fault_reset_req && !any_fault) |=>
      count_q == 4'h0 && state_q == ST_RUN)
    else $error("Fault reset did not clear the count.");

  mf_brake_a: assert property (
    (outsel_q[OUT_SEL_W-1:0] == FUNC_BRAKE && brake_fault &&
     $stable(outsel_q)) |=> mf_out[0])
    else $error("Brake fault output not shown.");

endmodule

/* sim/far_plant.sv */
// Behavioural far side: fault detectors and run status of the power stage.
// Assumes the bench sets fault levels and a run enable on core_clk.
`timescale 1ns/1ps

module far_plant
  import far_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire far_fault_t fault_req,
  input  wire logic       run_en,
  input  wire logic       protect_stop,
  input  wire logic       coast_stop,
  output far_fault_t      fault_in,
  output logic            drive_running
);
  // ************************************************************
  // Detector levels and run status.
  // ************************************************************

  // Detectors switch on the falling edge, so the controller's
  // synchronisers see levels that are not aligned to its own edge.
  always @(negedge core_clk) begin
    fault_in <= fault_req;
  end

  // The stage stops on a trip, a coast request or any live fault.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drive_running <= 1'b0;
    end else begin
      drive_running <= run_en & ~protect_stop & ~coast_stop & ~|fault_in;
    end
  end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the fault auto-restart controller.
// Assumes the behavioural plant model and shortened poll and clean counts.
`timescale 1ns/1ps

module tb_top;
  import far_pkg::*;
  localparam int PC = 20;
  localparam int CC = 200;
  logic             core_clk  = 1'b0;
  logic             rstn      = 1'b0;
  logic [7:0]       reg_addr  = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic             run_en    = 1'b1;
  far_fault_t       fault_req = '0;
  far_fault_t       fault_in;
  logic [31:0]      reg_rdata;
  logic             drive_running;
  logic             restart_cmd;
  logic             protect_stop;
  logic             coast_stop;
  logic             resistor_alarm;
  logic             fault_contact;
  logic [OUT_N-1:0] mf_out;
  logic             rd_d      = 1'b0;
  logic [31:0]      exp_q[$];
  logic [31:0]      msk_q[$];
  logic [31:0]      rnd       = 32'd6490;
  logic [31:0]      cfg       = 32'h0;
  int               n_errors  = 0;
  int               checks    = 0;
  int               n_restart = 0;
  int               idx_r     = 0;
  int               idx_b     = 0;

  // Half period of 2.5 ns gives the 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  far_ctrl #(.POLL_CYCLES(20'(PC)), .CLEAN_CYCLES(37'(CC))) uut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_in(fault_in),
    .drive_running(drive_running), .restart_cmd(restart_cmd),
    .protect_stop(protect_stop), .coast_stop(coast_stop),
    .resistor_alarm(resistor_alarm), .fault_contact(fault_contact),
    .mf_out(mf_out));

  far_plant plant (
    .core_clk(core_clk), .rstn(rstn), .fault_req(fault_req),
    .run_en(run_en), .protect_stop(protect_stop),
    .coast_stop(coast_stop), .fault_in(fault_in),
    .drive_running(drive_running));

  // ************************************************************
  // Helpers and bus tasks.
  // ************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp,
                        input logic [31:0] m);
    chk_out(got & m, exp & m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // The expected word is noted when the read is issued.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (restart_cmd === 1'b1) n_restart <= n_restart + 1;
    if (rd_d) chk_rd(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
  end

  task automatic wait_restart(input int n0);
    int k;
    for (k = 0; k < 4 * PC && n_restart == n0; k++) @(posedge core_clk);
    settle(2);
    chk_out(n_restart, n0 + 1);
  endtask

  // Raise one fault, hold it over several polls, check state and outputs,
  // then clear it and expect a restart, a trip to reset, or nothing.
  task automatic hit(input int b, input logic [3:0] st, input logic rest);
    int   n0;
    logic poll;
    logic trip;
    logic rh;
    n0   = n_restart;
    poll = (st == 4'h2);
    trip = (st == 4'h8);
    rh   = (b == 7) && cfg[CFG_RESPROT_BIT];
    @(posedge core_clk);
    fault_req <= far_fault_t'(FAULT_W'(1) << b);
    settle(3 * PC);
    chk_out(n_restart, n0);
    rd(STATUS_OFS, ((32'h1 << b) << STAT_FAULT_LSB) | (st << STAT_STATE_LSB),
       (st == 4'h1) ? 32'hF0 : 32'h3FFFF0);
    chk_out({protect_stop, coast_stop, resistor_alarm, fault_contact,
             mf_out},
            {trip, rh, rh, trip | (poll & cfg[CFG_CONTACT_BIT]),
             (5'(poll) << idx_r) |
             (5'(rh | (b == 8)) << idx_b)});
    @(posedge core_clk);
    fault_req <= '0;
    if (poll) begin
      wait_restart(n0);
    end else begin
      settle(10);
      if (trip) wr(CMD_OFS, 32'h1);
      settle(4);
    end
    if (rest) settle(CC + 50);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  initial begin
    #(60000 * 5);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(CFG_OFS, 32'h0, 32'hFFFFFFFF);
    rd(STATUS_OFS, 32'h10, 32'hFFFFFFFF);
    rnd = xorshift(rnd);
    wr(8'h10, rnd);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    rd(CMD_OFS, 32'h0, 32'hFFFFFFFF);
    wr(CFG_OFS, 32'hF);
    rd(CFG_OFS, 32'hA, 32'hF);
    wr(CFG_OFS, 32'h0);
    hit(0, 4'h8, 1'b0);
    rnd = xorshift(rnd);
    // Output 0 carries the brake code, the restart code a random other one.
    idx_r = 1 + int'(rnd % 4);
    idx_b = 0;
    wr(OUTSEL_OFS, (32'(FUNC_RESTART) << (6 * idx_r)) |
                   (32'(FUNC_BRAKE) << (6 * idx_b)));
    // Every fault kind with protection and ride-through on.
    for (int b = 0; b < FAULT_W; b++) begin
      cfg = {24'h0, RIDE_CONT_A, 1'b1, 1'(b), LIMIT_MAX};
      wr(CFG_OFS, cfg);
      hit(b, (b == 13) ? 4'h8 : 4'h2, 1'b1);
    end
    for (int r = 0; r < 3; r++) begin
      cfg = {24'h0, 2'(r), 6'h0A};
      wr(CFG_OFS, cfg);
      hit(4, (r == 0) ? 4'h8 : 4'h2, 1'b1);
    end
    hit(7, 4'h1, 1'b0);
    hit(8, 4'h2, 1'b1);
    // Attempt counting with a limit of three.
    cfg = 32'h3;
    wr(CFG_OFS, cfg);
    hit(0, 4'h2, 1'b0);
    hit(0, 4'h2, 1'b0);
    rd(STATUS_OFS, 32'h11, 32'hFF);
    hit(0, 4'h2, 1'b0);
    hit(0, 4'h8, 1'b0);
    rd(STATUS_OFS, 32'h10, 32'hFF);
    hit(0, 4'h2, 1'b0);
    hit(0, 4'h2, 1'b0);
    run_en <= 1'b0;
    settle(CC + 50);
    rd(STATUS_OFS, 32'h1, 32'hF);
    run_en <= 1'b1;
    settle(CC + 50);
    rd(STATUS_OFS, 32'h0, 32'hF);
    hit(0, 4'h2, 1'b0);
    hit(0, 4'h2, 1'b0);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(STATUS_OFS, 32'h10, 32'hFFFFFFFF);
    rd(CFG_OFS, 32'h0, 32'hFFFFFFFF);
    settle(4);
    complete_run();
  end
endmodule
